// ==== core/pmic_onoff_regs.svh ====
// Purpose: Offsets, field positions, reset values and timing counts of the on/off controller pair.
// Assumes: A 125 MHz system clock.
// Notes: Times are kept in their own unit; cycle counts are derived in the modules.
`ifndef PMIC_ONOFF_REGS_SVH
`define PMIC_ONOFF_REGS_SVH
// Device registers, reached over the link.
`define DEV_ADDR_BIAS 2'h0
`define DEV_ADDR_SOFTRST 2'h1
`define DEV_ADDR_PERIPH 2'h2
`define DEV_ADDR_STATCLR 2'h3
`define SOFTRST_COLD 2'h1
`define SOFTRST_OFF 2'h2
// Host registers, reached over APB.
`define HOST_ADDR_CTRL 12'h000
`define HOST_ADDR_CMD 12'h004
`define HOST_ADDR_STATUS 12'h008
`define CTRL_HOLD_BIT 0
`define CMD_ADDR_LSB 8
`define RESET_CTRL 32'h0000_0000
// Timing.
`define CLK_KHZ 125000
`define CHG_DB_MS 120
`define BTN_DB_MS 30
`define HOLD_WAIT_MS 1000
`define POWER_UP_CYC 16
`define POWER_DOWN_CYC 16
`define SHUTDOWN_CYC 4
`define BIAS_OFF_CYC 4
`endif

// ==== core/pmic_onoff_pkg.sv ====
// Purpose: Types shared by both ends of the on/off controller link.
// Assumes: Nothing beyond the header.
// Notes: State codes are one-hot so the host can read them directly.
package pmic_onoff_pkg;
   typedef enum logic [8:0] {
      ST_STANDBY = 9'h001,
      ST_SW_ON = 9'h002,
      ST_BIAS_WAIT = 9'h004,
      ST_POWER_UP = 9'h008,
      ST_HOLD_WAIT = 9'h010,
      ST_ON = 9'h020,
      ST_POWER_DOWN = 9'h040,
      ST_SHUTDOWN = 9'h080,
      ST_BIAS_OFF = 9'h100
   } onoff_state_e;
   typedef logic [1:0] link_addr_t;
   typedef logic [7:0] link_data_t;
endpackage : pmic_onoff_pkg

// ==== core/pmic_link_if.sv ====
// Purpose: Link between the host processor end and the power controller end.
// Assumes: Both ends on sys_clk.
// Notes: One write strobe per register write; status is a continuous level.
interface pmic_link_if;
   import pmic_onoff_pkg::*;
   logic wrStb;
   link_addr_t wrAddr;
   link_data_t wrData;
   logic powerHoldIn;
   logic [8:0] devState;
   logic [2:0] devFlags;
   modport dev (input wrStb, input wrAddr, input wrData, input powerHoldIn, output devState, output devFlags);
   modport host (output wrStb, output wrAddr, output wrData, output powerHoldIn, input devState, input devFlags);
endinterface : pmic_link_if

// ==== core/power_on_off_state_controller.sv ====
// Purpose: On/off controller of a small power-management device.
// Assumes: All inputs synchronous to sys_clk; lockout inputs already filtered.
// Notes: The power sequencer is reduced to fixed step counts.
`include "pmic_onoff_regs.svh"
module power_on_off_state_controller
   import pmic_onoff_pkg::*;
#(
   parameter int unsigned CHG_DB_CYC = `CHG_DB_MS * `CLK_KHZ,
   parameter int unsigned BTN_DB_CYC = `BTN_DB_MS * `CLK_KHZ,
   parameter int unsigned HOLD_WAIT_CYC = `HOLD_WAIT_MS * `CLK_KHZ,
   parameter int unsigned PERIPH_W = 4
)
(
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // Link to the host.
   pmic_link_if.dev link,
   // Wake sources and supervisors.
   input wire logic push_button_n,
   input wire logic charger_input_present,
   input wire logic bias_ready,
   input wire logic manualReset,
   input wire logic overTempLockout,
   input wire logic sysBelowUvlo,
   input wire logic sysAboveUvloHys,
   input wire logic sysAboveOvlo,
   // Power controls.
   output logic mainBiasEn,
   output logic biasLowPower,
   output logic sequencer_slots,
   output logic [PERIPH_W-1:0] periphEn
);
   typedef struct packed {
      onoff_state_e st;
      logic btnLvl;
      logic [31:0] btnCnt;
      logic chgLvl;
      logic [31:0] chgCnt;
      logic [31:0] holdCnt;
      logic [7:0] seqCnt;
      logic swBias;
      logic [PERIPH_W-1:0] periphReg;
      logic internal_wake_flag;
      logic button_debounced_status;
      logic uvlo;
      logic mainBias;
      logic lowPower;
      logic slots;
      logic [PERIPH_W-1:0] periphOut;
      logic [8:0] stateOut;
      logic [2:0] flagsOut;
   } dev_s;

   dev_s q;
   dev_s d;
   logic btnWake;
   logic chgWake;
   logic wrBias;
   logic wrSoft;

   always_comb
   begin
      d = q;
      btnWake = 1'b0;
      chgWake = 1'b0;
      wrBias = link.wrStb && (link.wrAddr == `DEV_ADDR_BIAS);
      wrSoft = link.wrStb && (link.wrAddr == `DEV_ADDR_SOFTRST);
      // A level must hold steady for the full count before it is accepted.
      if (push_button_n == q.btnLvl)
      begin
         d.btnCnt = '0;
      end
      else if (q.btnCnt >= BTN_DB_CYC - 1)
      begin
         d.btnCnt = '0;
         d.btnLvl = push_button_n;
         btnWake = !push_button_n;
      end
      else
      begin
         d.btnCnt = q.btnCnt + 32'h1;
      end
      if (charger_input_present == q.chgLvl)
      begin
         d.chgCnt = '0;
      end
      else if (q.chgCnt >= CHG_DB_CYC - 1)
      begin
         d.chgCnt = '0;
         d.chgLvl = charger_input_present;
         chgWake = charger_input_present;
      end
      else
      begin
         d.chgCnt = q.chgCnt + 32'h1;
      end
      // Register writes are taken in every state.
      if (wrBias)
      begin
         d.swBias = link.wrData[0];
      end
      if (link.wrStb && (link.wrAddr == `DEV_ADDR_PERIPH))
      begin
         d.periphReg = link.wrData[PERIPH_W-1:0];
      end
      if (link.wrStb && (link.wrAddr == `DEV_ADDR_STATCLR) && link.wrData[0])
      begin
         d.button_debounced_status = 1'b0;
      end
      if (btnWake)
      begin
         d.button_debounced_status = 1'b1;
      end
      // Undervoltage latches low and releases only above the hysteresis point.
      if (sysBelowUvlo)
      begin
         d.uvlo = 1'b1;
      end
      else if (sysAboveUvloHys)
      begin
         d.uvlo = 1'b0;
      end
      d.seqCnt = q.seqCnt + 8'h1;
      case (q.st)
         ST_STANDBY:
         begin
            if (q.internal_wake_flag || btnWake || chgWake)
            begin
               d.st = ST_BIAS_WAIT;
               d.internal_wake_flag = 1'b0;
            end
            else if (wrBias && link.wrData[0])
            begin
               d.st = ST_SW_ON;
            end
         end
         ST_SW_ON:
         begin
            if (overTempLockout || q.uvlo)
            begin
               d.st = ST_SHUTDOWN;
            end
            else if (!q.swBias)
            begin
               d.st = ST_STANDBY;
            end
            else if (q.internal_wake_flag || btnWake || chgWake)
            begin
               d.st = ST_BIAS_WAIT;
               d.internal_wake_flag = 1'b0;
            end
         end
         ST_BIAS_WAIT:
         begin
            if (bias_ready)
            begin
               d.st = ST_POWER_UP;
            end
         end
         ST_POWER_UP:
         begin
            if (q.seqCnt >= 8'(`POWER_UP_CYC - 1))
            begin
               d.st = ST_HOLD_WAIT;
            end
         end
         ST_HOLD_WAIT:
         begin
            d.holdCnt = q.holdCnt + 32'h1;
            if (link.powerHoldIn)
            begin
               d.st = ST_ON;
            end
            else if (q.holdCnt >= HOLD_WAIT_CYC - 1)
            begin
               d.st = ST_POWER_DOWN;
            end
         end
         ST_ON:
         begin
            // Lockouts win over orderly power-down requests arriving together.
            if (overTempLockout || q.uvlo || sysAboveOvlo)
            begin
               d.st = ST_SHUTDOWN;
            end
            else if (wrSoft && (link.wrData[1:0] == `SOFTRST_COLD))
            begin
               d.st = ST_POWER_DOWN;
            end
            else if (wrSoft && (link.wrData[1:0] == `SOFTRST_OFF))
            begin
               d.st = ST_POWER_DOWN;
            end
            else if (!link.powerHoldIn || manualReset)
            begin
               d.st = ST_POWER_DOWN;
            end
         end
         ST_POWER_DOWN:
         begin
            if (q.seqCnt >= 8'(`POWER_DOWN_CYC - 1))
            begin
               d.st = ST_BIAS_OFF;
            end
         end
         ST_SHUTDOWN:
         begin
            if (q.seqCnt >= 8'(`SHUTDOWN_CYC - 1))
            begin
               d.st = ST_BIAS_OFF;
            end
         end
         ST_BIAS_OFF:
         begin
            if (q.seqCnt >= 8'(`BIAS_OFF_CYC - 1))
            begin
               d.st = ST_STANDBY;
            end
         end
         default:
         begin
            d.st = ST_STANDBY;
         end
      endcase
      // Set after the state logic, so a new cold reset wins over the clear of a wake being consumed.
      if (wrSoft && (link.wrData[1:0] == `SOFTRST_COLD))
      begin
         d.internal_wake_flag = 1'b1;
      end
      if (d.st != q.st)
      begin
         d.seqCnt = '0;
         d.holdCnt = '0;
      end
      // Outputs follow the next state so that they change with it.
      d.mainBias = !(d.st inside {ST_STANDBY, ST_BIAS_OFF});
      d.lowPower = (d.st == ST_ON);
      d.slots = (d.st == ST_ON) || (d.st == ST_HOLD_WAIT);
      d.periphOut = (d.st == ST_SW_ON) ? d.periphReg : '0;
      d.stateOut = d.st;
      d.flagsOut = {d.uvlo, d.internal_wake_flag, d.button_debounced_status};
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         q <= '{st: ST_STANDBY, btnLvl: 1'b1, stateOut: 9'h001, default: '0};
      end
      else if (clkEn)
      begin
         q <= d;
      end
   end

   assign mainBiasEn = q.mainBias;
   assign biasLowPower = q.lowPower;
   assign sequencer_slots = q.slots;
   assign periphEn = q.periphOut;
   assign link.devState = q.stateOut;
   assign link.devFlags = q.flagsOut;
endmodule : power_on_off_state_controller

// ==== core/power_host_controller.sv ====
// Purpose: Host end that turns APB register writes into link writes and drives power hold.
// Assumes: APB on sys_clk, 32-bit data.
// Notes: Every access answers in the first access cycle; pready comes from a flop.
`include "pmic_onoff_regs.svh"
module power_host_controller
   import pmic_onoff_pkg::*;
(
   // Clock, reset and enable.
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic clkEn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Link to the device.
   pmic_link_if.host link
);
   typedef struct packed {
      logic [31:0] rdata;
      logic ready;
      logic err;
      logic hold;
      logic stb;
      link_addr_t addr;
      link_data_t data;
   } host_s;

   host_s q;
   host_s d;
   logic mapped;
   logic doWrite;

   always_comb
   begin
      d = q;
      d.stb = 1'b0;
      mapped = (paddr == `HOST_ADDR_CTRL) || (paddr == `HOST_ADDR_CMD) || (paddr == `HOST_ADDR_STATUS);
      doWrite = psel && penable && q.ready && pwrite;
      // The answer is prepared in the setup cycle and shown in the access cycle.
      d.ready = psel && !penable;
      if (psel && !penable)
      begin
         d.err = !mapped;
         if (paddr == `HOST_ADDR_CTRL)
         begin
            d.rdata = {31'h0, q.hold};
         end
         else if (paddr == `HOST_ADDR_STATUS)
         begin
            d.rdata = {20'h0, link.devFlags, link.devState};
         end
         else
         begin
            d.rdata = 32'h0;
         end
      end
      if (doWrite && (paddr == `HOST_ADDR_CTRL))
      begin
         d.hold = pwdata[`CTRL_HOLD_BIT];
      end
      else if (doWrite && (paddr == `HOST_ADDR_CMD))
      begin
         d.stb = 1'b1;
         d.addr = pwdata[`CMD_ADDR_LSB+1:`CMD_ADDR_LSB];
         d.data = pwdata[7:0];
      end
   end

   always_ff @(posedge sys_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         q <= '0;
      end
      else if (clkEn)
      begin
         q <= d;
      end
   end

   assign prdata = q.rdata;
   assign pready = q.ready;
   assign pslverr = q.err;
   assign link.powerHoldIn = q.hold;
   assign link.wrStb = q.stb;
   assign link.wrAddr = q.addr;
   assign link.wrData = q.data;
endmodule : power_host_controller

// ==== sim/onoff_link_checker.sv ====
// Purpose: Assertions on the link between the host end and the device end.
// Assumes: One clock; the bench never raises a lockout during a link write.
// Notes: Lockouts are not seen here, so exits are checked only where none is raised.
module onoff_link_checker
   import pmic_onoff_pkg::*;
(
   // Clock and reset.
   input wire logic sys_clk,
   input wire logic nrst,
   // Link.
   input wire logic wrStb,
   input wire link_addr_t wrAddr,
   input wire link_data_t wrData,
   input wire logic powerHoldIn,
   input wire logic [8:0] devState,
   input wire logic [2:0] devFlags,
   // Power outputs.
   input wire logic mainBiasEn,
   input wire logic biasLowPower,
   input wire logic sequencer_slots
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!nrst);
   sequence up_end;
      devState == ST_POWER_UP ##1 devState == ST_HOLD_WAIT;
   endsequence
   sequence off_end;
      devState == ST_BIAS_OFF ##1 devState inside {ST_STANDBY, ST_BIAS_WAIT};
   endsequence
   standby_bias_off_a: assert property (devState == ST_STANDBY |-> !mainBiasEn && !sequencer_slots)
      else $error("bias or slots on in standby");
   bias_on_a: assert property (devState == ST_STANDBY && wrStb && wrAddr == 2'h0 && wrData[0]
      |=> devState == ST_SW_ON) else $error("bias enable did not reach software on");
   bias_off_a: assert property (devState == ST_SW_ON && wrStb && wrAddr == 2'h0 && !wrData[0]
      |=> devState == ST_SW_ON ##1 devState == ST_STANDBY) else $error("bias clear did not reach standby");
   wait_bias_a: assert property (devState == ST_BIAS_WAIT |-> mainBiasEn)
      else $error("bias off while waiting for bias ready");
   power_up_a: assert property ($rose(devState == ST_POWER_UP) |-> ##[14:16] up_end)
      else $error("power up length wrong");
   hold_enter_a: assert property (devState == ST_HOLD_WAIT && powerHoldIn |=> devState == ST_ON)
      else $error("hold high did not enter on");
   on_outputs_a: assert property (devState == ST_ON |-> mainBiasEn && biasLowPower && sequencer_slots)
      else $error("on state outputs wrong");
   hold_low_a: assert property (devState == ST_ON && !powerHoldIn && !wrStb
      |=> devState inside {ST_POWER_DOWN, ST_SHUTDOWN}) else $error("hold low kept on");
   cold_reset_a: assert property (devState == ST_ON && wrStb && wrAddr == 2'h1 && wrData[1:0] == 2'h1
      |=> devState == ST_POWER_DOWN && devFlags[1]) else $error("cold reset wrong");
   power_off_a: assert property (devState == ST_ON && wrStb && wrAddr == 2'h1 && wrData[1:0] == 2'h2
      |=> devState == ST_POWER_DOWN && !devFlags[1]) else $error("power off wrong");
   bias_off_end_a: assert property ($rose(devState == ST_BIAS_OFF) |-> ##[2:4] off_end)
      else $error("bias off did not end in standby");
endmodule : onoff_link_checker

// ==== sim/power_on_off_state_controller_tb.sv ====
// Purpose: Drives the host end over APB and the device inputs, and judges the states.
// Assumes: Debounce 4 and 8 cycles, hold wait 50 cycles.
// Notes: Outputs are read at the clock edge, so they show the value before it.
`include "pmic_onoff_regs.svh"
module power_on_off_state_controller_tb
   import pmic_onoff_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, nrst, psel, penable, pwrite, pready, pslverr, err, btnN, chg, bias_ready;
   logic mrst, otl, uvlo, uvHys, ovlo, mainBiasEn, lowPwr, slots;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] periphEn;
   int n_errors, checks, cyc;
   pmic_link_if link();
   power_host_controller i_power_host_controller(.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .link(link.host));
   power_on_off_state_controller #(.CHG_DB_CYC(8), .BTN_DB_CYC(4), .HOLD_WAIT_CYC(50))
      i_power_on_off_state_controller(.sys_clk(sys_clk), .nrst(nrst), .clkEn(1'b1), .link(link.dev),
      .push_button_n(btnN), .charger_input_present(chg), .bias_ready(bias_ready), .manualReset(mrst),
      .overTempLockout(otl), .sysBelowUvlo(uvlo), .sysAboveUvloHys(uvHys), .sysAboveOvlo(ovlo),
      .mainBiasEn(mainBiasEn), .biasLowPower(lowPwr), .sequencer_slots(slots), .periphEn(periphEn));
   onoff_link_checker i_onoff_link_checker(.sys_clk(sys_clk), .nrst(nrst), .wrStb(link.wrStb),
      .wrAddr(link.wrAddr), .wrData(link.wrData), .powerHoldIn(link.powerHoldIn), .devState(link.devState),
      .devFlags(link.devFlags), .mainBiasEn(mainBiasEn), .biasLowPower(lowPwr), .sequencer_slots(slots));
   initial
   begin
      sys_clk = 0;
      forever #4 sys_clk = ~sys_clk;
   end
   task finish_test;
      $display("Errors %0d checks %0d", n_errors, checks);
      if (n_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : finish_test
   task cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask : cmp
   // Waits for a state; the count left in cyc lets a caller judge a duration.
   task wst(input onoff_state_e s, input int lim);
      for (cyc = 0; cyc < lim; cyc++)
      begin
         if (link.devState === s)
            break;
         @(posedge sys_clk);
      end
      cmp("state", s, link.devState);
      if (link.devState !== s)
         finish_test();
   endtask : wst
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int i;
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      for (i = 0; i < 9; i++)
      begin
         @(posedge sys_clk);
         if (pready === 1'b1)
            break;
      end
      rd = prdata;
      err = pslverr;
      psel <= 0;
      penable <= 0;
      // One idle edge keeps a following call from driving psel twice in one time step.
      @(posedge sys_clk);
      if (i == 9)
      begin
         cmp("pready", 1, 0);
         finish_test();
      end
   endtask : apb
   task cmd(input logic [1:0] a, input logic [7:0] d);
      apb(1, `HOST_ADDR_CMD, {22'h0, a, d});
   endtask : cmd
   task hold(input logic v);
      apb(1, `HOST_ADDR_CTRL, {31'h0, v});
   endtask : hold
   task press;
      bias_ready <= 0;
      btnN <= 0;
      repeat (6) @(posedge sys_clk);
      btnN <= 1;
      repeat (6) @(posedge sys_clk);
   endtask : press
   // Bias ready is held back first, so the wait for it is seen.
   task wake_on(input logic h);
      wst(ST_BIAS_WAIT, 30);
      repeat (5) @(posedge sys_clk);
      cmp("biaswait", ST_BIAS_WAIT, link.devState);
      bias_ready <= 1;
      wst(ST_POWER_UP, 5);
      if (h)
      begin
         hold(1);
         wst(ST_ON, 40);
      end
      else
         wst(ST_HOLD_WAIT, 30);
   endtask : wake_on
   task t_sw_on;
      apb(0, `HOST_ADDR_STATUS, 32'h0);
      cmp("status", 32'h1, rd);
      apb(0, 12'h00c, 32'h0);
      cmp("slverr", 1, err);
      cmd(`DEV_ADDR_BIAS, 8'h01);
      wst(ST_SW_ON, 5);
      cmd(`DEV_ADDR_PERIPH, 8'h05);
      ovlo <= 1;
      repeat (4) @(posedge sys_clk);
      cmp("periph", 32'h5, periphEn);
      cmp("ovlo", ST_SW_ON, link.devState);
      ovlo <= 0;
      cmd(`DEV_ADDR_BIAS, 8'h00);
      wst(ST_STANDBY, 5);
      cmp("off", 0, {mainBiasEn, periphEn});
   endtask : t_sw_on
   task t_uvlo;
      cmd(`DEV_ADDR_BIAS, 8'h01);
      wst(ST_SW_ON, 5);
      uvlo <= 1;
      @(posedge sys_clk);
      uvlo <= 0;
      wst(ST_SHUTDOWN, 5);
      wst(ST_STANDBY, 20);
      cmp("uvlatch", 1, link.devFlags[2]);
      uvHys <= 1;
      @(posedge sys_clk);
      uvHys <= 0;
      @(posedge sys_clk);
      cmp("uvrelease", 0, link.devFlags[2]);
   endtask : t_uvlo
   task t_button;
      btnN <= 0;
      repeat (2) @(posedge sys_clk);
      btnN <= 1;
      repeat (6) @(posedge sys_clk);
      cmp("glitch", ST_STANDBY, link.devState);
      press();
      wake_on(1);
      cmp("btn", 1, link.devFlags[0]);
      cmp("on", 3'h7, {mainBiasEn, lowPwr, slots});
      apb(0, `HOST_ADDR_CTRL, 32'h0);
      cmp("ctrl", 32'h1, rd);
      hold(0);
      wst(ST_POWER_DOWN, 5);
      wst(ST_STANDBY, 40);
      cmd(`DEV_ADDR_STATCLR, 8'h01);
      repeat (2) @(posedge sys_clk);
      cmp("btnclr", 0, link.devFlags[0]);
   endtask : t_button
   task t_charger;
      bias_ready <= 0;
      chg <= 1;
      wake_on(0);
      wst(ST_POWER_DOWN, 70);
      cmp("holdwait", 50, cyc);
      wst(ST_STANDBY, 40);
      chg <= 0;
      repeat (12) @(posedge sys_clk);
   endtask : t_charger
   task t_exits;
      press();
      wake_on(1);
      cmd(`DEV_ADDR_SOFTRST, `SOFTRST_OFF);
      wst(ST_POWER_DOWN, 5);
      wst(ST_STANDBY, 40);
      cmp("nowake", 0, link.devFlags[1]);
      press();
      wake_on(1);
      cmd(`DEV_ADDR_SOFTRST, `SOFTRST_COLD);
      bias_ready <= 0;
      wst(ST_POWER_DOWN, 5);
      cmp("wake", 1, link.devFlags[1]);
      wake_on(1);
      mrst <= 1;
      @(posedge sys_clk);
      mrst <= 0;
      wst(ST_POWER_DOWN, 5);
      wst(ST_STANDBY, 40);
      press();
      wake_on(1);
      otl <= 1;
      wst(ST_SHUTDOWN, 5);
      wst(ST_BIAS_OFF, 10);
      wst(ST_STANDBY, 10);
      otl <= 0;
      press();
      wake_on(1);
      ovlo <= 1;
      wst(ST_SHUTDOWN, 5);
      ovlo <= 0;
      wst(ST_STANDBY, 20);
      hold(0);
   endtask : t_exits
   initial
   begin
      {nrst, psel, penable, pwrite, chg, bias_ready, mrst, otl, uvlo, uvHys, ovlo} = '0;
      btnN = 1;
      paddr = 12'h000;
      pwdata = 32'h0;
      repeat (8) @(posedge sys_clk);
      nrst <= 1;
      @(posedge sys_clk);
      t_sw_on();
      t_uvlo();
      t_button();
      t_charger();
      t_exits();
      finish_test();
   end
endmodule : power_on_off_state_controller_tb
